//--- src/ifs_pkg.sv
// Package of register map, field layout and timing constants for the sequencer
package ifs_pkg;
   // Serial register write addresses (read address is this minus one)
   localparam logic [15:0] ADDR_ROI_HEIGHT   = 16'h0009;
   localparam logic [15:0] ADDR_VERTICAL_BLANK_EXTRA = 16'h0089;
   localparam logic [15:0] ADDR_INTEG_LINES  = 16'h0091;
   localparam logic [15:0] ADDR_SHUTTER_MODE = 16'h01d1;
   localparam logic [15:0] ADDR_OP_STATE     = 16'h4019;
   localparam logic [15:0] ADDR_SCAN_CONFIG  = 16'h4021;
   localparam logic [15:0] ADDR_SEQ_STATUS   = 16'h4029;
   // Reset values
   localparam logic [15:0] RST_ROI_HEIGHT    = 16'h0860;
   localparam logic [15:0] RST_VERTICAL_BLANK_EXTRA  = 16'h0000;
   localparam logic [15:0] RST_INTEG_LINES   = 16'h0d66;
   localparam logic [15:0] RST_SHUTTER_MODE  = 16'h0000;
   localparam logic [15:0] RST_OP_STATE      = 16'h0000;
   localparam logic [15:0] RST_SCAN_CONFIG   = 16'h0002;
   // Field encodings
   localparam logic [1:0]  SHUT_GLOBAL       = 2'h0;
   localparam logic [1:0]  SHUT_ROLLING      = 2'h1;
   localparam logic [15:0] OP_CONT_RUN       = 16'h0003;
   localparam int          SCAN_TRI_BIT      = 0;
   localparam int          SCAN_DEPTH_LSB    = 1;
   // Frame wait holds at least this many line periods while the 16-bit line sums do not wrap
   localparam logic [15:0] VERTICAL_BLANK_MIN_LINES  = 16'h0001;
   // Serial frame: 16 address bits then 16 data bits
   localparam logic [4:0]  SPI_ADDR_LAST_BIT = 5'h0f;
   localparam logic [4:0]  SPI_DATA_LAST_BIT = 5'h1f;
   // Stage times in core clock cycles
   localparam int          PIX_READ_CYC      = 60;
   localparam int          LVDS_OUT_CYC      = 150;
   localparam logic [15:0] ADC_CYC_8B        = 16'h0040;
   localparam logic [15:0] ADC_CYC_10B       = 16'h0050;
   localparam logic [15:0] ADC_CYC_12B       = 16'h0070;
   localparam logic [15:0] ADC_CYC_14B       = 16'h0090;
   // Words per bank per row at full width
   localparam int          LINE_WORDS_DEF    = 712;
   // Sync words, four per row edge on every bank
   localparam int          SYNC_LEN          = 4;
   localparam logic [9:0]  SYNC_W0           = 10'h3ff;
   localparam logic [9:0]  SYNC_W1           = 10'h000;
   localparam logic [9:0]  SYNC_W2           = 10'h000;
   localparam logic [9:0]  SYNC_SOF          = 10'h300;
   localparam logic [9:0]  SYNC_SOL          = 10'h200;
   localparam logic [9:0]  SYNC_EOF          = 10'h380;
   localparam logic [9:0]  SYNC_EOL          = 10'h280;
   localparam int          NUM_BANKS         = 8;
   localparam int          PIX_BITS          = 10;

   typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} ifs_seq_t;
   typedef enum logic [1:0] {OUT_IDLE, OUT_HEAD, OUT_DATA, OUT_TAIL} ifs_out_t;
endpackage : ifs_pkg

//--- src/ifs_frame_sequencer.sv
// Frame and line sequencer with serial register port and LVDS bank output
`timescale 1ns/10ps
module ifs_frame_sequencer
   import ifs_pkg::*;
#(
   parameter int LINE_WORDS = LINE_WORDS_DEF,
   parameter int PIX_CYC    = PIX_READ_CYC,
   parameter int LVDS_CYC   = LVDS_OUT_CYC
)(
   // Core clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Serial control port
   input  wire logic        spiSclk,
   input  wire logic        spiCs_b,
   input  wire logic        spiMosi,
   output logic             spiMiso,
   // Frame trigger pin
   input  wire logic        frameTrigger,
   // Sequencer status
   output logic             globalIntegrate,
   output logic             rowStartPulse,
   output logic [15:0]      rowStartPair,
   output logic             readoutActive,
   // LVDS output banks
   input  wire logic        lvdsClk,
   output logic [79:0]      bankData,
   output logic             bankValid,
   output logic             bankSync
);
   initial begin
      if (LINE_WORDS < 1 || LINE_WORDS > 65535 || PIX_CYC < 1 ||
          PIX_CYC > 30000 || LVDS_CYC < 1 || LVDS_CYC > 65535)
         $error("ifs_frame_sequencer: parameter out of range");
   end

   localparam logic [15:0] PIX16  = 16'(PIX_CYC);
   localparam logic [15:0] LVDS16 = 16'(LVDS_CYC);
   localparam logic [15:0] WLAST  = 16'(LINE_WORDS - 1);

   function automatic logic [15:0] max2(input logic [15:0] a,
                                        input logic [15:0] b);
      max2 = (a > b) ? a : b;
   endfunction : max2

   function automatic logic [15:0] adcCycles(input logic [1:0] depth);
      case (depth)
         2'h0:    adcCycles = ADC_CYC_8B;
         2'h1:    adcCycles = ADC_CYC_10B;
         2'h2:    adcCycles = ADC_CYC_12B;
         default: adcCycles = ADC_CYC_14B;
      endcase
   endfunction : adcCycles

   // Pin synchronisers
   logic sclkMeta, sclkSync, sclkPrev, csMeta, csSync, mosiMeta, mosiSync;
   logic trigMeta, trigSync;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         {sclkMeta, sclkSync, sclkPrev} <= 3'h0;
         {csMeta, csSync} <= 2'h3;
         {mosiMeta, mosiSync} <= 2'h0;
         {trigMeta, trigSync} <= 2'h0;
      end else begin
         sclkMeta <= spiSclk;
         sclkSync <= sclkMeta;
         sclkPrev <= sclkSync;
         csMeta   <= spiCs_b;
         csSync   <= csMeta;
         mosiMeta <= spiMosi;
         mosiSync <= mosiMeta;
         trigMeta <= frameTrigger;
         trigSync <= trigMeta;
      end
   end

   // Serial slave
   logic [4:0]  bitCnt;
   logic [15:0] shiftIn, shiftOut, spiAddr;
   logic        misoReg;
   wire         sclkRise = sclkSync & ~sclkPrev & ~csSync;
   wire         sclkFall = ~sclkSync & sclkPrev & ~csSync;
   wire [15:0]  wordIn   = {shiftIn[14:0], mosiSync};
   wire         addrDone = sclkRise && bitCnt == SPI_ADDR_LAST_BIT;
   wire         regWr    = sclkRise && bitCnt == SPI_DATA_LAST_BIT &&
                           spiAddr[0];
   wire [15:0]  readAddr = {wordIn[15:1], 1'b1};

   // Registers
   logic [15:0] roiHReg, vblankReg, integReg, shutterReg, opStateReg;
   logic [15:0] scanReg;
   ifs_seq_t    state;
   logic        integOn, haveData;
   logic [7:0]  frameCount;
   wire  [15:0] statusWord = {state == SEQ_RUN, integOn, haveData, 5'h00,
                              frameCount};

   function automatic logic [15:0] regRead(input logic [15:0] a);
      case (a)
         ADDR_ROI_HEIGHT:   regRead = roiHReg;
         ADDR_VERTICAL_BLANK_EXTRA: regRead = vblankReg;
         ADDR_INTEG_LINES:  regRead = integReg;
         ADDR_SHUTTER_MODE: regRead = shutterReg;
         ADDR_OP_STATE:     regRead = opStateReg;
         ADDR_SCAN_CONFIG:  regRead = scanReg;
         ADDR_SEQ_STATUS:   regRead = statusWord;
         default:           regRead = 16'h0000;
      endcase
   endfunction : regRead

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bitCnt   <= 5'h00;
         shiftIn  <= 16'h0000;
         shiftOut <= 16'h0000;
         spiAddr  <= 16'h0000;
         misoReg  <= 1'b0;
      end else if (csSync) begin
         bitCnt <= 5'h00;
      end else begin
         if (sclkRise) begin
            bitCnt  <= 5'(bitCnt + 5'h01);
            shiftIn <= wordIn;
         end
         if (addrDone) begin
            spiAddr <= wordIn;
            if (!wordIn[0])
               shiftOut <= regRead(readAddr);
         end else if (sclkFall && bitCnt[4]) begin
            misoReg  <= shiftOut[15];
            shiftOut <= {shiftOut[14:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         roiHReg    <= RST_ROI_HEIGHT;
         vblankReg  <= RST_VERTICAL_BLANK_EXTRA;
         integReg   <= RST_INTEG_LINES;
         shutterReg <= RST_SHUTTER_MODE;
         opStateReg <= RST_OP_STATE;
         scanReg    <= RST_SCAN_CONFIG;
      end else if (regWr) begin
         case (spiAddr)
            ADDR_ROI_HEIGHT:   roiHReg    <= {wordIn[15:1], 1'b0};
            ADDR_VERTICAL_BLANK_EXTRA: vblankReg  <= wordIn;
            ADDR_INTEG_LINES:  integReg   <= wordIn;
            ADDR_SHUTTER_MODE: shutterReg <= {14'h0000, wordIn[1:0]};
            ADDR_OP_STATE:     opStateReg <= wordIn;
            ADDR_SCAN_CONFIG:  scanReg    <= {13'h0000, wordIn[2:0]};
            default:           ;
         endcase
      end
   end

   // Line length in core clock cycles, frame arithmetic in line periods
   wire [15:0] adcCyc     = adcCycles(scanReg[SCAN_DEPTH_LSB +: 2]);
   wire [15:0] dualLen    = max2(LVDS16, 16'(PIX16 + adcCyc));
   wire [15:0] triLen     = max2(max2(PIX16, adcCyc), LVDS16);
   wire [15:0] lineLen    = scanReg[SCAN_TRI_BIT] ? triLen : dualLen;
   wire [15:0] readLines  = {1'b0, roiHReg[15:1]};
   wire [15:0] vbLines    = 16'(vblankReg + VERTICAL_BLANK_MIN_LINES);
   wire [15:0] frameLines = max2(16'(readLines + vbLines), integReg);
   wire [15:0] intStart   = 16'(frameLines - integReg);
   wire        runReq     = opStateReg == OP_CONT_RUN || trigSync;

   logic [15:0] lineCnt, linePos;
   wire  lineEnd  = lineCnt >= 16'(lineLen - 16'h0001);
   wire  [15:0] nextPos = (linePos >= 16'(frameLines - 16'h0001)) ?
                          16'h0000 : 16'(linePos + 16'h0001);
   wire  wrapNow  = nextPos == 16'h0000;
   wire  startNow = runReq && nextPos == intStart;
   wire  goIdle   = wrapNow && !integOn && !startNow;
   wire  continuous_run_state  = state == SEQ_RUN;
   wire  lineStart = continuous_run_state && lineCnt == 16'h0000;
   wire  readNow  = continuous_run_state && haveData && linePos < readLines;
   wire  [15:0] rollOffs = (linePos >= intStart) ?
                          16'(linePos - intStart) :
                          16'(linePos + frameLines - intStart);
   wire  rollStart = lineStart && shutterReg[1:0] == SHUT_ROLLING &&
                     rollOffs < readLines &&
                     (integOn || (haveData && linePos < intStart));

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state      <= SEQ_IDLE;
         lineCnt    <= 16'h0000;
         linePos    <= 16'h0000;
         integOn    <= 1'b0;
         haveData   <= 1'b0;
         frameCount <= 8'h00;
      end else begin
         case (state)
            SEQ_IDLE: begin
               if (runReq) begin
                  state    <= SEQ_RUN;
                  lineCnt  <= 16'h0000;
                  linePos  <= intStart;
                  integOn  <= 1'b1;
                  haveData <= 1'b0;
               end
            end
            SEQ_RUN: begin
               if (!lineEnd) begin
                  lineCnt <= 16'(lineCnt + 16'h0001);
               end else begin
                  lineCnt <= 16'h0000;
                  linePos <= nextPos;
                  if (wrapNow) begin
                     haveData <= integOn;
                     integOn  <= startNow;
                     if (integOn)
                        frameCount <= 8'(frameCount + 8'h01);
                     if (goIdle)
                        state <= SEQ_IDLE;
                  end else if (startNow) begin
                     integOn <= 1'b1;
                  end
               end
            end
            default: state <= SEQ_IDLE;
         endcase
      end
   end

   // Status outputs and line request toward the link domain
   logic        reqTgl, xFirst, xLast;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         globalIntegrate <= 1'b0;
         rowStartPulse   <= 1'b0;
         rowStartPair    <= 16'h0000;
         readoutActive   <= 1'b0;
         spiMiso         <= 1'b0;
         reqTgl          <= 1'b0;
         xFirst          <= 1'b0;
         xLast           <= 1'b0;
      end else begin
         globalIntegrate <= continuous_run_state && integOn &&
                            shutterReg[1:0] == SHUT_GLOBAL;
         rowStartPulse   <= rollStart;
         rowStartPair    <= rollStart ? rollOffs : rowStartPair;
         readoutActive   <= readNow;
         spiMiso         <= misoReg;
         if (lineStart && readNow) begin
            reqTgl <= ~reqTgl;
            xFirst <= linePos == 16'h0000;
            xLast  <= linePos == 16'(readLines - 16'h0001);
         end
      end
   end

   // Link domain: reset and request crossing
   logic     rstMeta_b, rstL_b, reqMeta, reqSync, reqPrev;
   logic     lFirst, lLast;
   ifs_out_t phase;
   logic [15:0] wordCnt;
   always_ff @(posedge lvdsClk) begin
      rstMeta_b <= rst_b;
      rstL_b    <= rstMeta_b;
   end
   always_ff @(posedge lvdsClk) begin
      if (!rstL_b) begin
         {reqMeta, reqSync, reqPrev} <= 3'h0;
      end else begin
         reqMeta <= reqTgl;
         reqSync <= reqMeta;
         reqPrev <= reqSync;
      end
   end
   wire reqEdge = reqSync ^ reqPrev;
   wire syncEnd = wordCnt == 16'(SYNC_LEN - 1);

   always_ff @(posedge lvdsClk) begin
      if (!rstL_b) begin
         phase   <= OUT_IDLE;
         wordCnt <= 16'h0000;
         lFirst  <= 1'b0;
         lLast   <= 1'b0;
      end else if (reqEdge) begin
         phase   <= OUT_HEAD;
         wordCnt <= 16'h0000;
         lFirst  <= xFirst;
         lLast   <= xLast;
      end else begin
         wordCnt <= 16'(wordCnt + 16'h0001);
         case (phase)
            OUT_IDLE: wordCnt <= 16'h0000;
            OUT_HEAD: if (syncEnd) begin
               phase   <= OUT_DATA;
               wordCnt <= 16'h0000;
            end
            OUT_DATA: if (wordCnt == WLAST) begin
               phase   <= OUT_TAIL;
               wordCnt <= 16'h0000;
            end
            OUT_TAIL: if (syncEnd) begin
               phase   <= OUT_IDLE;
               wordCnt <= 16'h0000;
            end
            default: phase <= OUT_IDLE;
         endcase
      end
   end

   // Bank word: sync code or pixel pattern standing in for converter data
   wire [9:0] edgeCode = (phase == OUT_HEAD) ?
                         (lFirst ? SYNC_SOF : SYNC_SOL) :
                         (lLast ? SYNC_EOF : SYNC_EOL);
   wire [9:0] syncWord = (wordCnt[1:0] == 2'h0) ? SYNC_W0 :
                         (wordCnt[1:0] == 2'h1) ? SYNC_W1 :
                         (wordCnt[1:0] == 2'h2) ? SYNC_W2 : edgeCode;
   wire       inSync   = phase == OUT_HEAD || phase == OUT_TAIL;
   logic [79:0] bankNext;
   always_comb begin
      bankNext = 80'h0;
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (inSync)
            bankNext[b*PIX_BITS +: PIX_BITS] = syncWord;
         else if (phase == OUT_DATA)
            bankNext[b*PIX_BITS +: PIX_BITS] =
               {b[0], 9'({wordCnt, 2'h0} + 18'(b / 2))};
      end
   end

   always_ff @(posedge lvdsClk) begin
      if (!rstL_b) begin
         bankData  <= 80'h0;
         bankValid <= 1'b0;
         bankSync  <= 1'b0;
      end else begin
         bankData  <= bankNext;
         bankValid <= phase != OUT_IDLE;
         bankSync  <= inSync;
      end
   end

   // Checks
   chk_write_odd_only: assert property (@(posedge clk) disable iff (!rst_b)
      $changed(shutterReg) |-> $past(regWr) && $past(spiAddr[0]))
      else $error("shutter register changed without odd-address write");
   chk_row_sync_lead: assert property (@(posedge lvdsClk) disable iff (!rstL_b)
      $rose(bankValid) |-> bankSync [*4] ##1 !bankSync)
      else $error("row did not open with four sync words");
   chk_row_sync_tail: assert property (@(posedge lvdsClk) disable iff (!rstL_b)
      $fell(bankValid) |-> $past(bankSync) && !$past(bankSync, 5))
      else $error("row did not close with four sync words");
   chk_line_period: assert property (@(posedge clk) disable iff (!rst_b)
      continuous_run_state && $past(continuous_run_state) && lineCnt == 16'h0000 && $stable(lineLen)
      |-> $past(lineCnt) == 16'(lineLen - 16'h0001))
      else $error("line period differs from stage maximum");
   chk_tri_longest: assert property (@(posedge clk) disable iff (!rst_b)
      scanReg[SCAN_TRI_BIT] |-> lineLen >= adcCyc && lineLen >= PIX16 &&
      lineLen >= LVDS16 && lineLen <= dualLen)
      else $error("tri-scan line period not the longest stage");
   chk_frame_fits: assert property (@(posedge clk) disable iff (!rst_b)
      continuous_run_state |-> linePos < frameLines && frameLines >= integReg &&
      frameLines >= 16'(readLines + vbLines))
      else $error("frame length does not cover its phases");
   chk_global_only: assert property (@(posedge clk) disable iff (!rst_b)
      shutterReg[1:0] != SHUT_GLOBAL && $past(shutterReg[1:0]) != SHUT_GLOBAL
      |-> !globalIntegrate)
      else $error("global integrate raised outside global shutter");
   chk_run_start: assert property (@(posedge clk) disable iff (!rst_b)
      state == SEQ_IDLE && runReq |=> continuous_run_state && integOn &&
      linePos == $past(intStart))
      else $error("capture did not begin on run request");
   chk_trig_rerun: assert property (@(posedge clk) disable iff (!rst_b)
      continuous_run_state && lineEnd && wrapNow && startNow |=> integOn ##1 continuous_run_state)
      else $error("held trigger did not start another frame");
   chk_readout_first: assert property (@(posedge clk) disable iff (!rst_b)
      continuous_run_state && lineEnd && wrapNow && integOn |=> haveData && linePos == 0)
      else $error("readout did not follow integration end");
   chk_odd_bank_row: assert property (@(posedge lvdsClk) disable iff (!rstL_b)
      bankValid && !bankSync |-> bankData[19] && !bankData[9])
      else $error("row parity on wrong bank");
   chk_trig_sync: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(trigSync) |-> $past(trigMeta) && !$past(trigMeta, 2))
      else $error("trigger used without two-stage synchroniser");
endmodule : ifs_frame_sequencer

//--- bench/ifs_ctrl_model.sv
// Camera controller model: serial master and LVDS bank receiver
`timescale 1ns/10ps
module ifs_ctrl_model
   import ifs_pkg::*;
#(
   parameter int LW = 8
)(
   // Clocks
   input  wire logic        clk,
   input  wire logic        lvdsClk,
   // Serial port
   output logic             spiSclk,
   output logic             spiCs_b,
   output logic             spiMosi,
   input  wire logic        spiMiso,
   // LVDS banks
   input  wire logic [79:0] bankData,
   input  wire logic        bankValid,
   input  wire logic        bankSync
);
   int         idx = 0, frames = 0, rows = 0, rowsLast = 0, errs = 0;
   int         lineNs = 0, frameNs = 0;
   realtime    tRow = 0, t300 = 0;
   logic [9:0] tailCode = 10'h000, w, ex;
   initial begin
      spiSclk = 1'b0;
      spiCs_b = 1'b1;
      spiMosi = 1'b0;
   end
   // One serial frame; odd address writes, even address reads
   task automatic xfer(input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      logic [31:0] f;
      f = {a, d};
      q = 16'h0000;
      @(negedge clk);
      spiCs_b = 1'b0;
      for (int i = 0; i < 32; i++) begin
         spiMosi = f[31-i];
         repeat (6) @(negedge clk);
         if (i >= 16) q = {q[14:0], spiMiso};
         spiSclk = 1'b1;
         repeat (6) @(negedge clk);
         spiSclk = 1'b0;
      end
      repeat (6) @(negedge clk);
      spiCs_b = 1'b1;
      spiMosi = ~spiMosi;
      repeat (6) @(negedge clk);
   endtask : xfer
   // Row capture and checking in the link domain
   always @(posedge lvdsClk) begin
      if (bankValid) begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            w = bankData[10*b +: 10];
            ex = {b[0], 9'(4 * (idx - SYNC_LEN) + b / 2)};
            if (idx >= SYNC_LEN && idx < SYNC_LEN + LW) begin
               if (bankSync || w !== ex) errs++;
            end else if (!bankSync || w !== (idx % 4 == 0 ? SYNC_W0 :
                         idx % 4 == 3 ? bankData[9:0] : SYNC_W1)) errs++;
         end
         if (idx == SYNC_LEN - 1) begin
            if (bankData[9:0] == SYNC_SOF) begin
               frameNs = int'($realtime - t300);
               t300 = $realtime;
               frames++;
               rowsLast = rows;
               rows = 0;
            end else begin
               lineNs = int'($realtime - tRow);
               if (bankData[9:0] !== SYNC_SOL) errs++;
            end
            tRow = $realtime;
         end
         if (idx == 2 * SYNC_LEN + LW - 1) begin
            tailCode = bankData[9:0];
            rows++;
         end
         idx++;
      end else idx = 0;
   end
endmodule : ifs_ctrl_model

//--- bench/ifs_frame_sequencer_tb.sv
// Self-checking bench for the frame sequencer
`timescale 1ns/10ps
module ifs_frame_sequencer_tb
   import ifs_pkg::*;
;
   localparam int LW = 8;
   logic        clk = 1'b0, lvdsClk = 1'b0, rst_b = 1'b0, frameTrigger = 1'b0;
   logic        spiSclk, spiCs_b, spiMosi, spiMiso, globalIntegrate;
   logic        rowStartPulse, readoutActive, bankValid, bankSync;
   logic [15:0] rowStartPair, q, prevPair = 16'h0000;
   logic [79:0] bankData;
   logic [31:0] lfsr = 32'h90eceb3a;
   int          fail_count = 0, checked = 0, giCnt = 0, giLast = 0, lp10;
   int          roCnt = 0, roLast = 0;
   always #25 clk = ~clk;
   always #16 lvdsClk = ~lvdsClk;
   ifs_frame_sequencer #(.LINE_WORDS(LW)) dut (.clk(clk), .rst_b(rst_b),
      .spiSclk(spiSclk), .spiCs_b(spiCs_b), .spiMosi(spiMosi),
      .spiMiso(spiMiso), .frameTrigger(frameTrigger),
      .globalIntegrate(globalIntegrate), .rowStartPulse(rowStartPulse),
      .rowStartPair(rowStartPair), .readoutActive(readoutActive),
      .lvdsClk(lvdsClk), .bankData(bankData), .bankValid(bankValid),
      .bankSync(bankSync));
   ifs_ctrl_model #(.LW(LW)) ctrl (.clk(clk), .lvdsClk(lvdsClk),
      .spiSclk(spiSclk), .spiCs_b(spiCs_b), .spiMosi(spiMosi),
      .spiMiso(spiMiso), .bankData(bankData), .bankValid(bankValid),
      .bankSync(bankSync));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic near(input int seen, input int exp);
      check({15'h0000, seen - exp < 100 && exp - seen < 100}, 16'h0001);
   endtask : near
   task automatic results();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic giveUp();
      fail_count++;
      $display("MISMATCH at %0t: wait ran out", $time);
      results();
   endtask : giveUp
   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsrNext
   function automatic int adcOf(input logic [1:0] d);
      return int'(d == 2'h0 ? ADC_CYC_8B : d == 2'h1 ? ADC_CYC_10B :
                  d == 2'h2 ? ADC_CYC_12B : ADC_CYC_14B);
   endfunction : adcOf
   function automatic int lineCyc(input logic triScan, input int adc);
      int m;
      m = (PIX_READ_CYC > adc) ? PIX_READ_CYC : adc;
      if (!triScan) m = PIX_READ_CYC + adc;
      return (LVDS_OUT_CYC > m) ? LVDS_OUT_CYC : m;
   endfunction : lineCyc
   task automatic waitFrames(input int n);
      int t;
      t = ctrl.frames + n;
      for (int i = 0; i < 40000 && ctrl.frames < t; i++) @(negedge clk);
      if (ctrl.frames < t) giveUp();
   endtask : waitFrames
   task automatic waitIdle();
      for (int i = 0; i < 60; i++) begin
         ctrl.xfer(ADDR_SEQ_STATUS - 16'h0001, 16'h0000, q);
         if (q[15:13] === 3'b000) return;
      end
      giveUp();
   endtask : waitIdle
   task automatic endFrames(input int f, input int lpx);
      near(ctrl.lineNs, 50 * lpx);
      if (f > 0) near(ctrl.frameNs, 50 * lpx * f);
      waitIdle();
      check(16'(ctrl.rowsLast), 16'h0004);
      check(16'(ctrl.errs), 16'h0000);
      check({6'h00, ctrl.tailCode}, {6'h00, SYNC_EOF});
      near(50 * roLast, 50 * lpx * 4);
   endtask : endFrames
   task automatic runCase(input logic [15:0] cfg, input logic [1:0] sh,
                          input logic [15:0] integ, input int lpx);
      ctrl.xfer(ADDR_SCAN_CONFIG, cfg, q);
      ctrl.xfer(ADDR_SHUTTER_MODE, {14'h0000, sh}, q);
      ctrl.xfer(ADDR_INTEG_LINES, integ, q);
      giLast = 0;
      ctrl.xfer(ADDR_OP_STATE, OP_CONT_RUN, q);
      waitFrames(3);
      ctrl.xfer(ADDR_OP_STATE, RST_OP_STATE, q);
      if (sh == SHUT_GLOBAL) near(50 * giLast, 50 * lpx * integ);
      endFrames((integ > 5) ? integ : 5, lpx);
      if (sh == SHUT_ROLLING) check(prevPair, 16'h0003);
      $display("test scan %h shutter %0d done", cfg, sh);
   endtask : runCase
   // Integration and readout window lengths, rolling row order
   always @(posedge clk) begin
      if (readoutActive === 1'b1) begin
         if (roCnt == 0 && giCnt != 0) begin
            giLast = giCnt;
            giCnt = 0;
         end
         roCnt++;
      end else if (roCnt != 0) begin
         roLast = roCnt;
         roCnt = 0;
      end
      if (globalIntegrate === 1'b1) giCnt++;
      else if (giCnt != 0) begin
         giLast = giCnt;
         giCnt = 0;
      end
      if (rowStartPulse === 1'b1) begin
         if (rowStartPair !== 16'h0000)
            check(rowStartPair, 16'(prevPair + 16'h0001));
         prevPair = rowStartPair;
      end
   end
   initial begin
      logic [15:0] ra [7] = '{ADDR_ROI_HEIGHT, ADDR_INTEG_LINES, 16'h1235,
         ADDR_SHUTTER_MODE, ADDR_OP_STATE, ADDR_SCAN_CONFIG, ADDR_VERTICAL_BLANK_EXTRA};
      logic [15:0] rv [7] = '{RST_ROI_HEIGHT, RST_INTEG_LINES, 16'h0000,
         RST_SHUTTER_MODE, RST_OP_STATE, RST_SCAN_CONFIG, RST_VERTICAL_BLANK_EXTRA};
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 7; i++) begin
         ctrl.xfer(ra[i] - 16'h0001, 16'h0000, q);
         check(q, rv[i]);
      end
      ctrl.xfer(ADDR_SHUTTER_MODE - 16'h0001, 16'h0001, q);
      ctrl.xfer(ADDR_SHUTTER_MODE - 16'h0001, 16'h0000, q);
      check(q, RST_SHUTTER_MODE);
      ctrl.xfer(ADDR_ROI_HEIGHT, 16'h0008, q);
      ctrl.xfer(ADDR_ROI_HEIGHT - 16'h0001, 16'h0000, q);
      check(q, 16'h0008);
      $display("test registers done");
      lp10 = lineCyc(1'b0, int'(ADC_CYC_10B));
      runCase(RST_SCAN_CONFIG, SHUT_ROLLING, 16'h0004, lp10);
      runCase(RST_SCAN_CONFIG, SHUT_GLOBAL, 16'h0004, lp10);
      lfsr = lfsrNext(lfsr);
      runCase({13'h0000, lfsr[4:3], 1'b0}, SHUT_GLOBAL, 16'h0004,
              lineCyc(1'b0, adcOf(lfsr[4:3])));
      runCase(16'h0007, SHUT_GLOBAL, 16'(6 + lfsr[2:0]),
              lineCyc(1'b1, int'(ADC_CYC_14B)));
      ctrl.xfer(ADDR_SCAN_CONFIG, RST_SCAN_CONFIG, q);
      ctrl.xfer(ADDR_INTEG_LINES, 16'h0004, q);
      @(negedge clk);
      frameTrigger = 1'b1;
      waitFrames(2);
      frameTrigger = 1'b0;
      endFrames(0, lp10);
      $display("test trigger done");
      results();
   end
endmodule : ifs_frame_sequencer_tb
